// *** rtl/adcsq_pkg.sv ***
// Package: register map, field positions and state encoding of the converter sequencer
package adcsq_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADCSQ_OFS_PWR_IRQ   = 8'h02; // power_irq_control
    localparam logic [7:0] ADCSQ_OFS_SEQ_LEN   = 8'h03; // sequence_length_control
    localparam logic [7:0] ADCSQ_OFS_TIM_RES   = 8'h04; // timing_resolution_control
    localparam logic [7:0] ADCSQ_OFS_SEQ_START = 8'h05; // sequence_start_control
    localparam logic [7:0] ADCSQ_OFS_STATUS0   = 8'h06; // converter_status0
    localparam logic [7:0] ADCSQ_OFS_CCF       = 8'h0B; // conv_complete_flags
    localparam logic [7:0] ADCSQ_OFS_DIEN      = 8'h0D; // digital_input_enable
    localparam logic [7:0] ADCSQ_OFS_PORT      = 8'h0F; // channel_port_data
    localparam logic [7:0] ADCSQ_OFS_RESULT    = 8'h10; // results, hi byte even, lo odd
    localparam logic [7:0] ADCSQ_RESULT_MASK   = 8'hF0;

    // ==========================================================
    // power_irq_control fields
    localparam int ADCSQ_B_POWER_UP  = 7; // converter_power_up
    localparam int ADCSQ_B_WAIT_HALT = 5; // wait_halt_select
    localparam int ADCSQ_B_TRIG_LVL  = 4; // trig_level_select
    localparam int ADCSQ_B_TRIG_POL  = 3; // trig_polarity
    localparam int ADCSQ_B_TRIG_EN   = 2; // trig_enable
    localparam int ADCSQ_B_IRQ_EN    = 1; // seq_done_irq_enable
    localparam int ADCSQ_B_IRQ_FLAG  = 0; // read-only copy of interrupt request

    // sequence_length_control: length field, zero means full length
    localparam int ADCSQ_LEN_LSB = 3;
    localparam int ADCSQ_LEN_MSB = 5;

    // timing_resolution_control fields
    localparam int ADCSQ_B_RES8    = 7; // res_eight_select
    localparam int ADCSQ_SMP_MSB   = 6; // sample_time_hi
    localparam int ADCSQ_SMP_LSB   = 5; // sample_time_lo
    localparam int ADCSQ_PRE_MSB   = 4; // clock_prescale
    localparam int ADCSQ_PRE_LSB   = 0;

    // sequence_start_control fields
    localparam int ADCSQ_B_RJUST = 7; // right-justified results
    localparam int ADCSQ_B_MULTI = 5; // multi_channel_select
    localparam int ADCSQ_B_SCAN  = 4; // continuous scan
    localparam int ADCSQ_CH_MSB  = 2; // starting channel
    localparam int ADCSQ_CH_LSB  = 0;

    // converter_status0 fields
    localparam int ADCSQ_B_SEQ_DONE = 7; // seq_done_flag, write 1 clears
    localparam int ADCSQ_B_OVERRUN  = 5; // trig_overrun_flag

    // ==========================================================
    // Reset values
    localparam logic [7:0] ADCSQ_RST_CTRL = 8'h00;
    localparam logic [7:0] ADCSQ_RST_PORT = 8'hFF;

    // Trigger pin and sample phase base length in converter clock ticks
    localparam int         ADCSQ_TRIG_CH   = 7; // analog_channel_seven
    localparam logic [4:0] ADCSQ_SMP_BASE  = 5'h02;

    // Sequencer states
    typedef enum logic [2:0] {
        ADCSQ_IDLE    = 3'b001,
        ADCSQ_SAMPLE  = 3'b010,
        ADCSQ_CONVERT = 3'b100
    } adcsq_state_t;

endpackage : adcsq_pkg

// *** rtl/adcsq_top.sv ***
// Sequencer, trigger, low-power and register control of an eight-channel SAR converter
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int NUM_CH  = 8,
    parameter int RES_MAX = 10
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // Pads and analog front end
    input  wire logic [NUM_CH-1:0]     pad_level,
    input  wire logic                  comp_above,
    output logic      [2:0]            channel_sel,
    output logic      [RES_MAX-1:0]    dac_code,
    output logic                       analog_power,
    output logic                       sample_clk_en,
    output logic                       convert_clk_en,
    output logic      [NUM_CH-1:0]     din_buf_en,
    // Low-power modes and interrupt
    input  wire logic                  stop_mode,
    input  wire logic                  wait_mode,
    output logic                       seq_done_irq
);
    import adcsq_pkg::*;

    // ==========================================================
    // Registers and state
    logic [7:0]               pwr_ctl_r;
    logic [7:0]               len_ctl_r;
    logic [7:0]               tim_ctl_r;
    logic [7:0]               start_ctl_r;
    logic [NUM_CH-1:0]        dien_r;
    logic                     seq_done_r;
    logic                     overrun_r;
    logic [NUM_CH-1:0]        ccf_r;
    logic [RES_MAX-1:0]       result_r [NUM_CH];
    logic [NUM_CH-1:0]        pad_s1_r;
    logic [NUM_CH-1:0]        pad_s2_r;
    logic                     trig_prev_r;
    adcsq_state_t             state_r;
    logic [5:0]               pre_cnt_r;
    logic [4:0]               smp_cnt_r;
    logic [3:0]               bit_idx_r;
    logic [2:0]               conv_idx_r;
    logic [RES_MAX-1:0]       sar_r;
    logic [7:0]               rdata_r;
    logic                     irq_r;
    logic [2:0]               chan_r;

    // Decoded controls
    logic                     trig_en, trig_lvl, trig_pol, scan, halt;
    logic                     trig_active, trig_edge, busy, tick;
    logic                     sw_start, start, abort, seq_end, conv_end;
    logic                     wr_pwr, wr_start;
    logic [3:0]               seq_len;
    logic [3:0]               msb_idx;
    logic [4:0]               smp_last;
    logic [5:0]               pre_last;
    logic [RES_MAX-1:0]       sar_kept;
    logic [RES_MAX-1:0]       rd_res;
    logic [RES_MAX-1:0]       rj_res;

    assign wr_pwr   = reg_wr && (reg_addr == ADCSQ_OFS_PWR_IRQ);
    assign wr_start = reg_wr && (reg_addr == ADCSQ_OFS_SEQ_START);
    assign trig_en  = pwr_ctl_r[ADCSQ_B_TRIG_EN];
    assign trig_lvl = pwr_ctl_r[ADCSQ_B_TRIG_LVL];
    assign trig_pol = pwr_ctl_r[ADCSQ_B_TRIG_POL];
    assign scan     = start_ctl_r[ADCSQ_B_SCAN];
    assign busy     = (state_r != ADCSQ_IDLE);

    // ==========================================================
    // Pad synchronisers; the first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            pad_s1_r    <= '0;
            pad_s2_r    <= '0;
            trig_prev_r <= 1'b0;
        end else begin
            pad_s1_r    <= pad_level;
            pad_s2_r    <= pad_s1_r;
            trig_prev_r <= pad_s2_r[ADCSQ_TRIG_CH];
        end
    end

    // Trigger taken from channel seven, polarity applied
    assign trig_active = trig_en && (pad_s2_r[ADCSQ_TRIG_CH] == trig_pol);
    assign trig_edge   = trig_en && !trig_lvl && trig_active
                         && (trig_prev_r != trig_pol);

    // ==========================================================
    // Start, abort and halt decisions
    always_comb begin
        halt     = stop_mode || (wait_mode && pwr_ctl_r[ADCSQ_B_WAIT_HALT]);
        abort    = wr_pwr && (!reg_wdata[ADCSQ_B_POWER_UP]
                              || !reg_wdata[ADCSQ_B_IRQ_EN]);
        sw_start = wr_start && !trig_en;
        start    = 1'b0;
        if (pwr_ctl_r[ADCSQ_B_POWER_UP] && !abort) begin
            if (sw_start) begin
                start = 1'b1;
            end else if (trig_edge && !busy) begin
                start = 1'b1;
            end else if (trig_en && trig_lvl && trig_active && !busy) begin
                start = 1'b1;
            end
        end
    end

    // ==========================================================
    // Control register writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            pwr_ctl_r   <= ADCSQ_RST_CTRL;
            len_ctl_r   <= ADCSQ_RST_CTRL;
            tim_ctl_r   <= ADCSQ_RST_CTRL;
            start_ctl_r <= ADCSQ_RST_CTRL;
            dien_r      <= '0;
        end else begin
            if (wr_pwr) begin
                pwr_ctl_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADCSQ_OFS_SEQ_LEN) begin
                len_ctl_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADCSQ_OFS_TIM_RES) begin
                tim_ctl_r <= reg_wdata;
            end
            if (wr_start) begin
                start_ctl_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == ADCSQ_OFS_DIEN) begin
                dien_r <= reg_wdata[NUM_CH-1:0];
            end
        end
    end

    // ==========================================================
    // Converter clock prescaler: one tick every 2*(prescale+1) clocks
    assign pre_last = {tim_ctl_r[ADCSQ_PRE_MSB:ADCSQ_PRE_LSB], 1'b1};
    assign tick     = busy && !halt && (pre_cnt_r == pre_last);

    always_ff @(posedge mclk) begin
        if (reset) begin
            pre_cnt_r <= '0;
        end else if (!busy || start) begin
            pre_cnt_r <= '0;
        end else if (!halt) begin
            pre_cnt_r <= tick ? 6'h00 : pre_cnt_r + 6'h01;
        end
    end

    // ==========================================================
    // Sequencer
    assign seq_len  = (len_ctl_r[ADCSQ_LEN_MSB:ADCSQ_LEN_LSB] == 3'h0)
                      ? 4'(NUM_CH) : {1'b0, len_ctl_r[ADCSQ_LEN_MSB:ADCSQ_LEN_LSB]};
    // Eight-bit mode stops the search two steps early, leaving bits left-aligned
    assign msb_idx  = 4'(RES_MAX - 1);
    assign smp_last = (ADCSQ_SMP_BASE << tim_ctl_r[ADCSQ_SMP_MSB:ADCSQ_SMP_LSB]) - 5'h01;
    assign conv_end = (state_r == ADCSQ_CONVERT) && tick
                      && (bit_idx_r == (tim_ctl_r[ADCSQ_B_RES8] ? 4'h2 : 4'h0));
    assign seq_end  = conv_end && ({1'b0, conv_idx_r} == seq_len - 4'h1);

    // Keep the trial bit only when the sample sits above the trial level
    always_comb begin
        sar_kept = sar_r;
        if (!comp_above) begin
            sar_kept[bit_idx_r] = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r    <= ADCSQ_IDLE;
            smp_cnt_r  <= '0;
            bit_idx_r  <= '0;
            conv_idx_r <= '0;
            sar_r      <= '0;
        end else if (abort || !pwr_ctl_r[ADCSQ_B_POWER_UP]) begin
            state_r <= ADCSQ_IDLE;
            sar_r   <= '0;
        end else if (start) begin
            state_r    <= ADCSQ_SAMPLE;
            smp_cnt_r  <= '0;
            conv_idx_r <= '0;
            sar_r      <= '0;
        end else begin
            unique case (state_r)
                ADCSQ_IDLE: begin
                    sar_r <= '0;
                end
                ADCSQ_SAMPLE: begin
                    if (tick) begin
                        smp_cnt_r <= smp_cnt_r + 5'h01;
                        if (smp_cnt_r == smp_last) begin
                            state_r   <= ADCSQ_CONVERT;
                            bit_idx_r <= msb_idx;
                            sar_r     <= '0;
                            sar_r[msb_idx] <= 1'b1;                           // first trial
                        end
                    end
                end
                ADCSQ_CONVERT: begin
                    if (tick) begin
                        if (conv_end) begin
                            smp_cnt_r <= '0;
                            sar_r     <= '0;
                            if (!seq_end) begin
                                state_r    <= ADCSQ_SAMPLE;
                                conv_idx_r <= conv_idx_r + 3'h1;
                            end else if ((!trig_en && scan) ||
                                         (trig_en && trig_lvl && trig_active)) begin
                                state_r    <= ADCSQ_SAMPLE;
                                conv_idx_r <= '0;
                            end else begin
                                state_r <= ADCSQ_IDLE;
                            end
                        end else begin
                            bit_idx_r <= bit_idx_r - 4'h1;
                            sar_r     <= sar_kept | (10'(1) << (bit_idx_r - 4'h1));
                        end
                    end
                end
                default: begin
                    state_r <= ADCSQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Results; channel seven data is junk under external trigger
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_r[i] <= '0;
            end
        end else if (conv_end && !abort) begin
            result_r[conv_idx_r] <= sar_kept;
        end
    end

    // ==========================================================
    // Status flags: hardware set wins over clear for seq_done_r; for overrun_r and ccf_r a start clears over a set or a completion
    always_ff @(posedge mclk) begin
        if (reset) begin
            seq_done_r <= 1'b0;
            overrun_r  <= 1'b0;
            ccf_r      <= '0;
        end else begin
            if (seq_end && !abort) begin
                seq_done_r <= 1'b1;
            end else if (reg_wr && reg_addr == ADCSQ_OFS_STATUS0
                         && reg_wdata[ADCSQ_B_SEQ_DONE]) begin
                seq_done_r <= 1'b0;
            end
            // Level mode never reaches here: trig_edge is edge mode only
            if (trig_edge && busy && !start) begin
                overrun_r <= 1'b1;
            end else if (start) begin
                overrun_r <= 1'b0;
            end
            if (start) begin
                ccf_r <= '0;
            end else if (conv_end && !abort) begin
                ccf_r[conv_idx_r] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read path; data stands only in the cycle after the strobe
    assign rd_res = result_r[reg_addr[3:1]];
    assign rj_res = tim_ctl_r[ADCSQ_B_RES8] ? (rd_res >> 2) : rd_res;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (!reg_rd) begin
            rdata_r <= '0;
        end else if ((reg_addr & ADCSQ_RESULT_MASK) == ADCSQ_OFS_RESULT) begin
            if (start_ctl_r[ADCSQ_B_RJUST]) begin
                rdata_r <= reg_addr[0] ? rj_res[7:0] : {6'h00, rj_res[9:8]};
            end else begin
                rdata_r <= reg_addr[0] ? {rd_res[1:0], 6'h00} : rd_res[9:2];
            end
        end else begin
            unique case (reg_addr)
                ADCSQ_OFS_PWR_IRQ:   rdata_r <= {pwr_ctl_r[7:1], irq_r};
                ADCSQ_OFS_SEQ_LEN:   rdata_r <= len_ctl_r;
                ADCSQ_OFS_TIM_RES:   rdata_r <= tim_ctl_r;
                ADCSQ_OFS_SEQ_START: rdata_r <= start_ctl_r;
                ADCSQ_OFS_STATUS0:   rdata_r <= {seq_done_r, 1'b0, overrun_r, 2'b00,
                                                 conv_idx_r};
                ADCSQ_OFS_CCF:       rdata_r <= ccf_r;
                ADCSQ_OFS_DIEN:      rdata_r <= dien_r;
                ADCSQ_OFS_PORT:      rdata_r <= pad_s2_r | ~dien_r;
                default:             rdata_r <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Registered outputs to the analog side and interrupt
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_r  <= 1'b0;
            chan_r <= '0;
        end else begin
            irq_r  <= seq_done_r && pwr_ctl_r[ADCSQ_B_IRQ_EN];
            chan_r <= start_ctl_r[ADCSQ_B_MULTI]
                      ? start_ctl_r[ADCSQ_CH_MSB:ADCSQ_CH_LSB] + conv_idx_r
                      : start_ctl_r[ADCSQ_CH_MSB:ADCSQ_CH_LSB];
        end
    end

    // Gating follows the sequencer so idle machines burn no clock power
    logic sample_en_r, convert_en_r, power_r;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sample_en_r  <= 1'b0;
            convert_en_r <= 1'b0;
            power_r      <= 1'b0;
        end else begin
            sample_en_r  <= (state_r == ADCSQ_SAMPLE) && !halt;
            convert_en_r <= (state_r == ADCSQ_CONVERT) && !halt;
            power_r      <= pwr_ctl_r[ADCSQ_B_POWER_UP];
        end
    end

    assign reg_rdata      = rdata_r;
    assign seq_done_irq   = irq_r;
    assign channel_sel    = chan_r;
    assign dac_code       = sar_r;
    assign analog_power   = power_r;
    assign sample_clk_en  = sample_en_r;
    assign convert_clk_en = convert_en_r;
    assign din_buf_en     = dien_r;

endmodule : adcsq_top

`default_nettype wire

// *** dv/adcsq_props.sv ***
// Checker: port-level properties of the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module adcsq_props
    import adcsq_pkg::*;
#(parameter int NUM_CH = 8) (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              reset,
    // Register port
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    // Converter side
    input wire logic              analog_power,
    input wire logic              sample_clk_en,
    input wire logic              convert_clk_en,
    input wire logic [NUM_CH-1:0] din_buf_en,
    input wire logic              stop_mode,
    input wire logic              wait_mode,
    input wire logic              seq_done_irq
);
    logic [7:0] ctl_r;
    logic       ctl_wr;
    logic       run;
    logic       sw_ok;
    // Shadow of the power and interrupt control byte
    assign ctl_wr = reg_wr && reg_addr == ADCSQ_OFS_PWR_IRQ;
    assign run = sample_clk_en | convert_clk_en;
    assign sw_ok = ctl_r[ADCSQ_B_POWER_UP] && !ctl_r[ADCSQ_B_TRIG_EN] && !stop_mode && !wait_mode;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl_r <= 8'h00;
        end else if (ctl_wr) begin
            ctl_r <= reg_wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    power_reset_a: assert property ($fell(reset) |-> !analog_power && !seq_done_irq)
        else $error("powered after reset");
    power_down_a: assert property (ctl_wr && !reg_wdata[ADCSQ_B_POWER_UP] |->
        ##2 (!analog_power && !run)) else $error("power-down did not abort");
    irq_abort_a: assert property (ctl_wr && !reg_wdata[ADCSQ_B_IRQ_EN] |-> ##2 !run)
        else $error("irq disable did not abort");
    clk_excl_a: assert property (!(sample_clk_en && convert_clk_en))
        else $error("both clocks on");
    stop_halt_a: assert property (stop_mode |=> !run)
        else $error("running in stop mode");
    dien_follow_a: assert property (reg_wr && reg_addr == ADCSQ_OFS_DIEN |=>
        din_buf_en == $past(reg_wdata)) else $error("buffer enables stale");
    sw_start_a: assert property ((reg_wr && reg_addr == ADCSQ_OFS_SEQ_START && sw_ok)
        ##1 (sw_ok && !reg_wr) |=> sample_clk_en) else $error("no start");
    irq_gate_a: assert property (seq_done_irq |-> $past(ctl_r[ADCSQ_B_IRQ_EN]))
        else $error("irq while disabled");
endmodule : adcsq_props
bind adcsq_top adcsq_props #(.NUM_CH(NUM_CH)) adcsq_props_i (.mclk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .analog_power, .sample_clk_en, .convert_clk_en, .din_buf_en,
    .stop_mode, .wait_mode, .seq_done_irq);
`default_nettype wire

// *** dv/adcsq_partner.sv ***
// Partner: analog sources and external trigger on the channel pads
`timescale 1ns/10ps
`default_nettype none
module adcsq_partner (
    // Converter side
    input  wire logic [2:0] channel_sel,
    input  wire logic [9:0] dac_code,
    output logic            comp_above,
    // Pad side
    input  wire logic [6:0] digital_in,
    input  wire logic       trigger_in,
    output logic      [7:0] pad_level
);
    // Fixed level per channel keeps results predictable
    assign comp_above = {channel_sel, 7'h2D} >= dac_code;
    // Trigger source rides on the channel seven pad
    assign pad_level = {trigger_in, digital_in};
endmodule : adcsq_partner
`default_nettype wire

// *** dv/test_adcsq_top.sv ***
// Testbench: registers, trigger modes, low power and sequences of the converter
`timescale 1ns/10ps
`default_nettype none
module test_adcsq_top;
    import adcsq_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, din_buf_en, pad_level;
    logic [6:0]  digital_in = 7'h00;
    logic        trigger_in = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0, clk_any;
    logic        comp_above, analog_power, sample_clk_en, convert_clk_en, seq_done_irq;
    logic [2:0]  channel_sel;
    logic [9:0]  dac_code;
    logic [15:0] lfsr = 16'h0769;
    int          errors = 0, tests_run = 0;
    always #25 mclk = ~mclk;
    always_comb clk_any = sample_clk_en | convert_clk_en;
    adcsq_top adcsq_top_i (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pad_level, .comp_above, .channel_sel, .dac_code, .analog_power, .sample_clk_en,
        .convert_clk_en, .din_buf_en, .stop_mode, .wait_mode, .seq_done_irq);
    adcsq_partner adcsq_partner_i (.channel_sel, .dac_code, .comp_above, .digital_in,
        .trigger_in, .pad_level);
    // Next random word of the bench's shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Expected result byte, left justified, from the partner's fixed level
    function automatic logic [7:0] res_byte(input logic [2:0] c, input logic lo);
        logic [9:0] v;
        v = {c, 7'h2D};
        return lo ? {v[1:0], 6'h00} : v[9:2];
    endfunction : res_byte
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] want, input logic [7:0] m = 8'hFF);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, want);
    endtask : rdc
    // Bounded wait; a missed deadline is a mismatch
    task automatic await(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check({7'h00, s}, 8'h01);
    endtask : await
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        rdc(ADCSQ_OFS_PWR_IRQ, 8'h00);
        rdc(ADCSQ_OFS_PORT, 8'hFF);
        rdc(8'h01, 8'h00);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            digital_in <= lfsr[6:0];
            wr(ADCSQ_OFS_DIEN, lfsr[15:8]);
            repeat (3) @(posedge mclk);
            rdc(ADCSQ_OFS_PORT, ~lfsr[15:8] | {1'b0, lfsr[6:0]});
        end
        // Software sequence in the recommended setup order
        wr(ADCSQ_OFS_PWR_IRQ, 8'h82);
        repeat (8) @(posedge mclk);
        wr(ADCSQ_OFS_SEQ_LEN, 8'h10);
        wr(ADCSQ_OFS_TIM_RES, 8'h00);
        wr(ADCSQ_OFS_SEQ_START, 8'h23);
        await(seq_done_irq, 400);
        rdc(ADCSQ_OFS_CCF, 8'h03);
        rdc(ADCSQ_OFS_RESULT, res_byte(3'h3, 1'b0));
        rdc(ADCSQ_OFS_RESULT + 8'h03, res_byte(3'h4, 1'b1));
        wr(ADCSQ_OFS_STATUS0, 8'h80);
        @(posedge mclk);
        #1 check({7'h00, seq_done_irq}, 8'h00);
        // Rising edge trigger; start-register writes must not start
        wr(ADCSQ_OFS_PWR_IRQ, 8'h8E);
        wr(ADCSQ_OFS_SEQ_START, 8'h00);
        repeat (6) @(posedge mclk);
        #1 check({7'h00, clk_any}, 8'h00);
        trigger_in <= 1'b1;
        await(sample_clk_en, 6);
        trigger_in <= 1'b0;
        repeat (4) @(posedge mclk);
        trigger_in <= 1'b1;
        await(seq_done_irq, 400);
        rdc(ADCSQ_OFS_STATUS0, 8'h20, 8'h20);
        wr(ADCSQ_OFS_STATUS0, 8'h80);
        // Active-low level trigger; toggles inside a sequence are no overrun
        wr(ADCSQ_OFS_PWR_IRQ, 8'h96);
        trigger_in <= 1'b0;
        await(sample_clk_en, 6);
        repeat (4) @(posedge mclk);
        trigger_in <= 1'b1;
        repeat (4) @(posedge mclk);
        trigger_in <= 1'b0;
        await(seq_done_irq, 400);
        await(sample_clk_en, 8);
        rdc(ADCSQ_OFS_STATUS0, 8'h00, 8'h20);
        stop_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check({7'h00, clk_any}, 8'h00);
        stop_mode <= 1'b0;
        await(clk_any, 4);
        // Wait mode halts only once the wait-halt bit is set
        wait_mode <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check({7'h00, clk_any}, 8'h01);
        wr(ADCSQ_OFS_PWR_IRQ, 8'hB6);
        repeat (2) @(posedge mclk);
        #1 check({7'h00, clk_any}, 8'h00);
        wait_mode <= 1'b0;
        await(clk_any, 4);
        // Abort: irq enable off, clear flag, then power down
        trigger_in <= 1'b1;
        wr(ADCSQ_OFS_PWR_IRQ, 8'h94);
        wr(ADCSQ_OFS_STATUS0, 8'h80);
        wr(ADCSQ_OFS_PWR_IRQ, 8'h00);
        wr(ADCSQ_OFS_DIEN, 8'h5A);
        wr(ADCSQ_OFS_SEQ_START, 8'h00);
        rdc(ADCSQ_OFS_DIEN, 8'h5A);
        #1 check({7'h00, clk_any}, 8'h00);
        report_and_stop();
    end
endmodule : test_adcsq_top
`default_nettype wire
